// ### hw/iqs_pkg.sv
// Package for the interrupt and queue status register block
package iqs_pkg;
   // Register word indices (printed offsets are word aligned: index * 4)
   localparam logic [7:0] IQS_IDX_ERR_WAKE = 8'h1c;
   localparam logic [7:0] IQS_IDX_PT_EVT = 8'h1d;
   localparam logic [7:0] IQS_IDX_LVL_LOW = 8'h1e;
   localparam logic [7:0] IQS_IDX_LVL_HIGH = 8'h1f;
   localparam logic [7:0] IQS_IDX_ERR_MASK = 8'h18;
   localparam logic [7:0] IQS_IDX_PT_MASK = 8'h19;
   // Field positions, error and wake-up status
   localparam int IQS_EW_CRC = 7;
   localparam int IQS_EW_PAR = 6;
   localparam int IQS_EW_SOFT = 5;
   localparam int IQS_EW_HARD = 4;
   localparam int IQS_EW_WT = 3;
   localparam int IQS_EW_AMP = 2;
   localparam int IQS_EW_PHASE = 1;
   localparam int IQS_EW_CAP = 0;
   // Field positions, passive target status
   localparam int IQS_PT_SLOT = 6;
   localparam int IQS_PT_FIELD_ON = 5;
   localparam int IQS_PT_AUTO_RESP = 4;
   localparam int IQS_PT_TYPE_F = 3;
   localparam int IQS_PT_A_STAR = 1;
   localparam int IQS_PT_A = 0;
   localparam logic [7:0] IQS_PT_RSVD_MASK = 8'h7b;
   // Field positions, second queue status
   localparam int IQS_Q2_CNT_LSB = 6;
   localparam int IQS_Q2_UNF = 5;
   localparam int IQS_Q2_OVR = 4;
   localparam int IQS_Q2_LB_LSB = 1;
   localparam int IQS_Q2_NP = 0;
   // Reset values and limits
   localparam logic [7:0] IQS_RST_STATUS = 8'h00;
   localparam logic [7:0] IQS_RST_MASK = 8'h00;
   localparam logic [9:0] IQS_LEVEL_MAX = 10'h200;
   localparam logic [3:0] IQS_FREE_SLOTS_LOW = 4'h4;
   // Event strobes from the surrounding receiver and target logic
   typedef struct packed {
      logic crc_err;
      logic parity_err;
      logic soft_framing;
      logic hard_framing;
      logic wake_timeout;
      logic amp_over_ref;
      logic phase_over_ref;
      logic cap_over_ref;
   } iqs_err_evt_s;
   typedef struct packed {
      logic cavoid_done_no_coll;
      logic field_turned_on;
      logic auto_resp_sent;
      logic sensf_resp_sent;
      logic a_starred_active;
      logic a_active;
   } iqs_pt_evt_s;
   // Queue state from the data queue
   typedef struct packed {
      logic [9:0] level;
      logic underflow;
      logic overflow;
      logic [2:0] last_byte_bit_count;
      logic last_byte_parity_missing;
   } iqs_queue_s;
endpackage

// ### hw/iqs_status_regs.sv
// Error, wake-up, passive target and queue status registers on AHB-Lite
//
// Contract
// RULE1: Flag crc, parity, soft framing, hard framing errors in bits 7..4.
// RULE2: Wake timer timeout sets bit 3 only when interrupt-every-timeout is selected.
// RULE3: Amplitude, phase, capacitance over reference set bits 2, 1, 0.
// RULE4: Error and wake-up status reads back then clears to zero.
// RULE5: Passive target status clears to zero once its read completes; code clears it at the address-phase edge, a cycle before the data phase ends.
// RULE6: Bit 6 set when four unused slot numbers remain.
// RULE7: Bit 5 set when collision avoidance ends clean and field is on.
// RULE8: Bit 4 set when target mode auto-sent an anticollision or SENSF_RES.
// RULE9: Bit 3 set after automatic 212/424 kb/s SENSF_REQ response sent.
// RULE10: Bit 1 set when type A target reaches starred active state.
// RULE11: Bit 0 set on plain active state; bits 7 and 2 reserved.
// RULE12: Queue level is ten bits, 0 to 512, low byte in first register.
// RULE13: Level bits 9..8 in bits 7..6, underflow bit 5, overflow bit 4.
// RULE14: Incomplete last byte bit count reported in bits 3..1.
// RULE15: Bit 0 flags a full last byte lacking its parity bit.
// RULE16: With hard framing set, bit count and parity flag are invalid.
// RULE17: Each error and wake-up event has a mask bit, reset 0, blocking irq.
// RULE18: Event in same cycle as the clearing read stays set.
// RULE19: Flags stay set from their event until their register is read.
`timescale 1ns/1ns
`default_nettype none
module iqs_status_regs
   import iqs_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Event strobes, same clock domain
   input wire iqs_err_evt_s err_evt,
   input wire logic wake_irq_every_timeout,
   input wire iqs_pt_evt_s pt_evt,
   input wire logic [3:0] free_slot_count,
   // Queue state, same clock domain
   input wire iqs_queue_s queue,
   // Interrupt request line toward the main interrupt logic
   output logic err_wake_irq
);

   logic [7:0] err_status_reg;
   logic [7:0] err_status_next;
   logic [7:0] pt_status_reg;
   logic [7:0] pt_status_next;
   logic [7:0] err_mask_reg;
   logic [7:0] pt_mask_reg;
   logic [7:0] err_set;
   logic [7:0] pt_set;
   logic [3:0] free_slot_prev_reg;
   logic [7:0] q_low;
   logic [7:0] q_high;
   logic [9:0] level_clamped;
   logic [7:0] rd_index;
   logic [7:0] wr_index_reg;
   logic wr_pend_reg;
   logic [7:0] rd_byte;
   logic addr_phase;
   logic rd_err_hit;
   logic rd_pt_hit;

   // Address phase accepted this edge
   assign addr_phase = hsel && hready && htrans[1];
   assign rd_index = haddr[9:2];
   assign rd_err_hit = addr_phase && !hwrite && (rd_index == IQS_IDX_ERR_WAKE);
   assign rd_pt_hit = addr_phase && !hwrite && (rd_index == IQS_IDX_PT_EVT);

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Error and wake-up event set terms
   always_comb begin
      err_set = 8'h00;
      err_set[IQS_EW_CRC] = err_evt.crc_err; // RULE1
      err_set[IQS_EW_PAR] = err_evt.parity_err; // RULE1
      err_set[IQS_EW_SOFT] = err_evt.soft_framing; // RULE1
      err_set[IQS_EW_HARD] = err_evt.hard_framing; // RULE1
      err_set[IQS_EW_WT] = err_evt.wake_timeout && wake_irq_every_timeout; // RULE2
      err_set[IQS_EW_AMP] = err_evt.amp_over_ref; // RULE3
      err_set[IQS_EW_PHASE] = err_evt.phase_over_ref; // RULE3
      err_set[IQS_EW_CAP] = err_evt.cap_over_ref; // RULE3
   end

   // Passive target set terms; slot level fires on reaching four
   always_comb begin
      pt_set = 8'h00;
      pt_set[IQS_PT_SLOT] = (free_slot_count == IQS_FREE_SLOTS_LOW) &&
                            (free_slot_prev_reg != IQS_FREE_SLOTS_LOW); // RULE6
      pt_set[IQS_PT_FIELD_ON] = pt_evt.cavoid_done_no_coll &&
                                pt_evt.field_turned_on; // RULE7
      pt_set[IQS_PT_AUTO_RESP] = pt_evt.auto_resp_sent; // RULE8
      pt_set[IQS_PT_TYPE_F] = pt_evt.sensf_resp_sent; // RULE9
      pt_set[IQS_PT_A_STAR] = pt_evt.a_starred_active; // RULE10
      pt_set[IQS_PT_A] = pt_evt.a_active; // RULE11
      pt_set = pt_set & IQS_PT_RSVD_MASK; // RULE11
   end

   // Sticky flags: clear on read, a coincident set wins
   always_comb begin
      err_status_next = err_status_reg;
      if (rd_err_hit) begin
         err_status_next = IQS_RST_STATUS; // RULE4
      end
      err_status_next = err_status_next | err_set; // RULE18 RULE19
   end

   always_comb begin
      pt_status_next = pt_status_reg;
      if (rd_pt_hit) begin
         pt_status_next = IQS_RST_STATUS; // RULE5
      end
      pt_status_next = pt_status_next | pt_set; // RULE18 RULE19
   end

   // Status flag storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_status_reg <= IQS_RST_STATUS;
         pt_status_reg <= IQS_RST_STATUS;
      end else begin
         err_status_reg <= err_status_next;
         pt_status_reg <= pt_status_next;
      end
   end

   // Previous slot count for edge detection, so the flag is not re-armed each cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         free_slot_prev_reg <= 4'h0;
      end else begin
         free_slot_prev_reg <= free_slot_count;
      end
   end

   // Write address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_index_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         wr_index_reg <= rd_index;
      end
   end

   // Mask registers, written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_mask_reg <= IQS_RST_MASK; // RULE17
         pt_mask_reg <= IQS_RST_MASK;
      end else if (wr_pend_reg) begin
         if (wr_index_reg == IQS_IDX_ERR_MASK) begin
            err_mask_reg <= hwdata[7:0];
         end
         if (wr_index_reg == IQS_IDX_PT_MASK) begin
            pt_mask_reg <= hwdata[7:0] & IQS_PT_RSVD_MASK;
         end
      end
   end

   // Unmasked error and wake-up flags drive the request line
   assign err_wake_irq = |(err_status_reg & ~err_mask_reg); // RULE17

   // Queue status views; level clamped to its legal range
   assign level_clamped = (queue.level > IQS_LEVEL_MAX) ? IQS_LEVEL_MAX : queue.level; // RULE12
   assign q_low = level_clamped[7:0]; // RULE12
   // Bit count and parity flag pass raw: invalid while hard framing is set
   assign q_high = {level_clamped[9:8], queue.underflow, queue.overflow,
                    queue.last_byte_bit_count, queue.last_byte_parity_missing}; // RULE13 RULE14 RULE15 RULE16

   // Read mux, sampled in the address phase
   always_comb begin
      case (rd_index)
         IQS_IDX_ERR_WAKE: rd_byte = err_status_reg; // RULE4
         IQS_IDX_PT_EVT: rd_byte = pt_status_reg; // RULE5
         IQS_IDX_LVL_LOW: rd_byte = q_low;
         IQS_IDX_LVL_HIGH: rd_byte = q_high;
         IQS_IDX_ERR_MASK: rd_byte = err_mask_reg;
         IQS_IDX_PT_MASK: rd_byte = pt_mask_reg;
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data register for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= {24'h00_0000, rd_byte};
      end
   end

endmodule
`default_nettype wire

// ### sim/iqs_host_model.sv
// Host bus master model issuing single word transfers
`timescale 1ns/1ns
`default_nettype none
module iqs_host_model (
   // Clock
   input wire logic hclk,
   // Master side of the bus
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   // Idle bus from time zero
   initial begin
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
   end
   // Bounded wait; a hung slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         iqs_status_regs_bench.errors++;
         iqs_status_regs_bench.end_sim();
      end
   endtask
   // Called just after a rising edge; holds each phase until ready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
endmodule
`default_nettype wire

// ### sim/iqs_status_regs_bench.sv
// Self-checking bench for the status register block
`timescale 1ns/1ns
`default_nettype none
module iqs_status_regs_bench
   import iqs_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic wake_irq_every_timeout = 1'b1;
   logic hsel, hwrite, hready, hresp, err_wake_irq;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [3:0] free_slot_count = 4'h0;
   iqs_err_evt_s err_evt = '0;
   iqs_pt_evt_s pt_evt = '0;
   iqs_queue_s queue = '0;
   int errors = 0;
   int check_count = 0;
   iqs_status_regs iqs_status_regs_i (.*, .hreadyout(hready));
   iqs_host_model iqs_host_model_i (.*);
   initial forever #5 hclk = ~hclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bus shorthands; writes discard the returned word
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      iqs_host_model_i.xfer(1'b0, a, 32'h0, d);
      check(d, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] d;
      iqs_host_model_i.xfer(1'b1, a, wd, d);
   endtask
   // One-cycle event strobes
   task automatic pulse(input logic [7:0] e, input logic [5:0] p);
      err_evt <= e;
      pt_evt <= p;
      @(posedge hclk);
      err_evt <= '0;
      pt_evt <= '0;
   endtask
   task automatic t_err();
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i, '0);
         @(posedge hclk);
         check(err_wake_irq, 1);
         rd_chk(12'h070, 32'h1 << i);
         check(err_wake_irq, 0);
         rd_chk(12'h070, 0);
      end
      wake_irq_every_timeout <= 1'b0;
      pulse(8'h08, '0);
      rd_chk(12'h070, 0);
      wake_irq_every_timeout <= 1'b1;
      rd_chk(12'h060, 0);
      wr(12'h060, 32'hff);
      rd_chk(12'h060, 32'hff);
      pulse(8'h80, '0);
      @(posedge hclk);
      check(err_wake_irq, 0);
      wr(12'h060, 0);
      rd_chk(12'h070, 32'h80);
      // Event racing the clearing read must survive it
      pulse(8'h40, '0);
      @(posedge hclk);
      fork
         rd_chk(12'h070, 32'h40);
         pulse(8'h80, '0);
      join
      rd_chk(12'h070, 32'h80);
   endtask
   task automatic t_pt();
      logic [5:0] ev[6] = '{6'h30, 6'h20, 6'h08, 6'h04, 6'h02, 6'h01};
      logic [7:0] ex[6] = '{8'h20, 8'h00, 8'h10, 8'h08, 8'h02, 8'h01};
      for (int i = 0; i < 6; i++) begin
         pulse('0, ev[i]);
         rd_chk(12'h074, {24'h0, ex[i]});
         rd_chk(12'h074, 0);
      end
      free_slot_count <= 4'h5;
      @(posedge hclk);
      free_slot_count <= 4'h4;
      @(posedge hclk);
      rd_chk(12'h074, 32'h40);
      wr(12'h074, 32'hff);
      rd_chk(12'h074, 0);
   endtask
   task automatic t_queue();
      logic [9:0] lv[5] = '{10'h000, 10'h001, 10'h0ff, 10'h100, 10'h200};
      for (int i = 0; i < 5; i++) begin
         queue <= {lv[i], 6'(i * 13)};
         @(posedge hclk);
         rd_chk(12'h078, {24'h0, lv[i][7:0]});
         rd_chk(12'h07c, {24'h0, lv[i][9:8], 6'(i * 13)});
      end
   endtask
   // Reset for 12 cycles, then scenarios
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_err();
      t_pt();
      t_queue();
      end_sim();
   end
endmodule
`default_nettype wire

// ### sim/iqs_status_regs_monitor.sv
// Checker for the status register block
`timescale 1ns/1ns
`default_nettype none
module iqs_status_regs_monitor
   import iqs_pkg::*;
(
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Events and queue
   input wire iqs_err_evt_s err_evt,
   input wire iqs_pt_evt_s pt_evt,
   input wire logic [3:0] free_slot_count,
   input wire iqs_queue_s queue
);
   // Read address phase and expected read images
   wire logic rd = hsel && hready && htrans[1] && !hwrite;
   wire logic [7:0] a = haddr[9:2];
   wire logic [7:0] ewe = err_evt & 8'hf7; // Wake bit depends on its gate
   wire logic [7:0] pte = {2'b00, &pt_evt[5:4], pt_evt[3:2], 1'b0, pt_evt[1:0]};
   wire logic [9:0] lvl = (queue.level > IQS_LEVEL_MAX) ? IQS_LEVEL_MAX : queue.level;
   wire logic [7:0] q2 = {lvl[9:8], queue[5:0]};
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Two reads with no event around the first
   sequence ew_twice;
      rd && a == 8'h1c && err_evt == '0 ##1 err_evt == '0 ##1 rd && a == 8'h1c;
   endsequence
   sequence pt_twice;
      rd && a == 8'h1d && pt_evt == '0 && $stable(free_slot_count)
         ##1 pt_evt == '0 && $stable(free_slot_count) ##1 rd && a == 8'h1d;
   endsequence
   ready_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   ew_clear_a: assert property (ew_twice |=> hrdata == 32'h0)
      else $error("error status not cleared");
   pt_clear_a: assert property (pt_twice |=> hrdata == 32'h0)
      else $error("target status not cleared");
   ew_latch_a: assert property (rd && a == 8'h1c |=> (hrdata[7:0] & $past(ewe, 2)) == $past(ewe, 2))
      else $error("error event lost");
   pt_latch_a: assert property (rd && a == 8'h1d |=> (hrdata[7:0] & $past(pte, 2)) == $past(pte, 2))
      else $error("target event lost");
   pt_rsvd_a: assert property (rd && a == 8'h1d |=> hrdata[31:8] == '0 && !hrdata[7] && !hrdata[2])
      else $error("reserved target bit set");
   lvl_low_a: assert property (rd && a == 8'h1e |=> hrdata == {24'h0, $past(lvl[7:0])})
      else $error("level low byte wrong");
   lvl_high_a: assert property (rd && a == 8'h1f |=> hrdata == {24'h0, $past(q2)})
      else $error("queue high byte wrong");
   rdata_hold_a: assert property (!rd |=> $stable(hrdata))
      else $error("read data moved");
endmodule
bind iqs_status_regs iqs_status_regs_monitor iqs_status_regs_monitor_i (.*);
`default_nettype wire
